// ===== shared/aac_defines.svh
`ifndef AAC_DEFINES_SVH
`define AAC_DEFINES_SVH

// Register byte addresses
`define AAC_ADDR_STATUS1 8'h00
`define AAC_ADDR_STATUS2 8'h04
`define AAC_ADDR_CMD1 8'h08
`define AAC_ADDR_CMD2 8'h0c
`define AAC_ADDR_CNT_MODE 8'h10
`define AAC_ADDR_CNT_DATA 8'h14
`define AAC_ADDR_CLEAR 8'h18
`define AAC_ADDR_FIFO 8'h1c

// Field positions
`define AAC_ST1_AVAIL 0
`define AAC_ST1_ERROR 1
`define AAC_ST2_OVERFLOW 0
`define AAC_ST2_OVERRUN 1
`define AAC_CMD1_SCAN_N 4
`define AAC_CMD2_DISABLE 1

// Counter mode command codes
`define AAC_MODE_RATE 8'h34
`define AAC_MODE_STOP 8'h30

// Timing
`define AAC_CLK_HZ 40000000
`define AAC_TICK_HZ 1000000
`define AAC_TICK_DIV (`AAC_CLK_HZ / `AAC_TICK_HZ)
`define AAC_MIN_INTERVAL 16'h000a

// Result store
`define AAC_FIFO_DEPTH 512
`define AAC_PTR_W 9
`define AAC_ADC_W 12

// Bus answers
`define AAC_RESP_OKAY 2'b00
`define AAC_RESP_SLVERR 2'b10

`endif

// ===== shared/aac_pkg.sv
package aac_pkg;
  // Sample-interval counter sequencing
  typedef enum logic [1:0] {
    AAC_CNT_IDLE = 2'b00,
    AAC_CNT_WAIT_LSB = 2'b01,
    AAC_CNT_WAIT_MSB = 2'b10,
    AAC_CNT_RUN = 2'b11
  } aac_cnt_state_t;
endpackage

// ===== hw/aac_acquisition.sv
// Overview of operation
// - Interval counter on 1 MHz, pulse every N.
// - Counter output rising edge starts one conversion.
// - Mode 34h selects rate mode, output high.
// - Counting starts after interval high byte write.
// - Mode 30h drives output low, halts acquisition.
// - External edge converts only while output high.
// - Disable bit blocks both trigger sources.
// - Status1 bit 0 shows FIFO not empty.
// - FIFO read returns oldest result, pops it.
// - 512-entry FIFO; full drops result, sets overflow.
// - Trigger during conversion skipped, sets overrun.
// - Error flag set when overflow or overrun.
// - Clear register write clears error flags.
// - No limit on number of conversions.
// - Result available within 9.5 us of trigger.
// - Result is sign-extended 16-bit two's complement.
//
// The address map and register access over AXI4-Lite were decided locally.
`include "aac_defines.svh"

module aac_acquisition (
  input wire logic aclk, // 40 MHz clock
  input wire logic aresetn, // Synchronous reset, low
  input wire logic [31:0] s_axi_awaddr, // Write address
  input wire logic [2:0] s_axi_awprot, // Unused protection
  input wire logic s_axi_awvalid, // Write address valid
  output logic s_axi_awready, // Write address ready
  input wire logic [31:0] s_axi_wdata, // Write data
  input wire logic [3:0] s_axi_wstrb, // Byte enables
  input wire logic s_axi_wvalid, // Write data valid
  output logic s_axi_wready, // Write data ready
  output logic [1:0] s_axi_bresp, // Write response
  output logic s_axi_bvalid, // Write response valid
  input wire logic s_axi_bready, // Write response ready
  input wire logic [31:0] s_axi_araddr, // Read address
  input wire logic [2:0] s_axi_arprot, // Unused protection
  input wire logic s_axi_arvalid, // Read address valid
  output logic s_axi_arready, // Read address ready
  output logic [31:0] s_axi_rdata, // Read data
  output logic [1:0] s_axi_rresp, // Read response
  output logic s_axi_rvalid, // Read data valid
  input wire logic s_axi_rready, // Read data ready
  input wire logic external_convert_n, // External trigger pin
  output logic convert_start, // One-cycle start to converter
  input wire logic convert_done, // Converter finished, same clock
  input wire logic [11:0] convert_data, // Converter result, signed
  output logic sample_counter_output, // Interval counter output
  output logic [3:0] channel_select, // Analog channel field
  output logic scan_enable_n, // Scan enable, low active
  output aac_pkg::aac_cnt_state_t counter_state // Counter sequencing state
);
  import aac_pkg::*;

  logic [7:0] aw_addr_q;
  logic aw_have_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic w_have_q;
  logic wr_fire;
  logic [7:0] wr_addr;
  logic rd_fire;
  logic [7:0] rd_addr;
  logic mapped_wr;
  logic [4:0] cmd1_q;
  logic acquisition_disable;
  aac_cnt_state_t cnt_state_q;
  logic [7:0] interval_lo_q;
  logic [15:0] interval_q;
  logic [15:0] count_q;
  logic [5:0] div_q;
  logic tick;
  logic out_q;
  logic out_prev_q;
  logic ext_s1_q;
  logic ext_s2_q;
  logic ext_prev_q;
  logic counter_rise;
  logic ext_rise;
  logic trigger;
  logic busy_q;
  logic overflow_flag_q;
  logic overrun_flag_q;
  logic result_available_flag;
  logic acquisition_error_flag;
  logic [15:0] fifo_mem [0:`AAC_FIFO_DEPTH-1];
  logic [`AAC_PTR_W-1:0] wr_ptr_q;
  logic [`AAC_PTR_W-1:0] rd_ptr_q;
  logic [`AAC_PTR_W:0] fill_q;
  logic fifo_full;
  logic push;
  logic pop;
  logic [15:0] result_word;

  // Write channel handshakes and decode
  assign s_axi_awready = !aw_have_q && !s_axi_bvalid;
  assign s_axi_wready = !w_have_q && !s_axi_bvalid;
  assign wr_fire = aw_have_q && w_have_q && !s_axi_bvalid;
  assign wr_addr = aw_addr_q;
  assign mapped_wr = (wr_addr == `AAC_ADDR_CMD1) || (wr_addr == `AAC_ADDR_CMD2) ||
    (wr_addr == `AAC_ADDR_CNT_MODE) || (wr_addr == `AAC_ADDR_CNT_DATA) ||
    (wr_addr == `AAC_ADDR_CLEAR);

  // Address and data are captured in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      aw_addr_q <= 8'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_have_q <= 1'b1;
      aw_addr_q <= {s_axi_awaddr[7:2], 2'b00};
    end else if (wr_fire) begin
      aw_have_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_have_q <= 1'b0;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_have_q <= 1'b1;
      w_data_q <= s_axi_wdata;
      w_strb_q <= s_axi_wstrb;
    end else if (wr_fire) begin
      w_have_q <= 1'b0;
    end
  end

  // Write response, one cycle after both halves are held
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `AAC_RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= mapped_wr ? `AAC_RESP_OKAY : `AAC_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Command registers, low byte lane
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cmd1_q <= 5'h10;
      acquisition_disable <= 1'b0;
    end else if (wr_fire && w_strb_q[0]) begin
      if (wr_addr == `AAC_ADDR_CMD1) begin
        cmd1_q <= w_data_q[4:0];
      end
      if (wr_addr == `AAC_ADDR_CMD2) begin
        acquisition_disable <= w_data_q[`AAC_CMD2_DISABLE];
      end
    end
  end

  assign channel_select = cmd1_q[3:0];
  assign scan_enable_n = cmd1_q[`AAC_CMD1_SCAN_N];

  // 1 MHz tick from the 40 MHz clock
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_q <= 6'h00;
    end else if (div_q == 6'(`AAC_TICK_DIV - 1)) begin
      div_q <= 6'h00;
    end else begin
      div_q <= div_q + 6'h01;
    end
  end

  assign tick = (div_q == 6'(`AAC_TICK_DIV - 1));

  // Interval counter: mode commands, byte loading and rate mode
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_state_q <= AAC_CNT_IDLE;
      out_q <= 1'b0;
      interval_lo_q <= 8'h00;
      interval_q <= 16'h0000;
      count_q <= 16'h0000;
    end else if (wr_fire && wr_addr == `AAC_ADDR_CNT_MODE && w_strb_q[0]) begin
      if (w_data_q[7:0] == `AAC_MODE_RATE) begin
        cnt_state_q <= AAC_CNT_WAIT_LSB;
        out_q <= 1'b1;
      end else if (w_data_q[7:0] == `AAC_MODE_STOP) begin
        cnt_state_q <= AAC_CNT_IDLE;
        out_q <= 1'b0;
      end
    end else if (wr_fire && wr_addr == `AAC_ADDR_CNT_DATA && w_strb_q[0]) begin
      if (cnt_state_q == AAC_CNT_WAIT_LSB) begin
        interval_lo_q <= w_data_q[7:0];
        cnt_state_q <= AAC_CNT_WAIT_MSB;
      end else if (cnt_state_q == AAC_CNT_WAIT_MSB) begin
        interval_q <= {w_data_q[7:0], interval_lo_q};
        count_q <= {w_data_q[7:0], interval_lo_q};
        cnt_state_q <= AAC_CNT_RUN;
      end
    end else if (cnt_state_q == AAC_CNT_RUN && tick) begin
      // Output dips low for the last tick, rises at reload
      if (count_q <= 16'h0001) begin
        count_q <= interval_q;
        out_q <= 1'b1;
      end else begin
        count_q <= count_q - 16'h0001;
        out_q <= (count_q != 16'h0002);
      end
    end
  end

  assign sample_counter_output = out_q;
  assign counter_state = cnt_state_q;

  // External pin through two flops, then edge memory
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ext_s1_q <= 1'b1;
      ext_s2_q <= 1'b1;
      ext_prev_q <= 1'b1;
      out_prev_q <= 1'b0;
    end else begin
      ext_s1_q <= external_convert_n;
      ext_s2_q <= ext_s1_q;
      ext_prev_q <= ext_s2_q;
      out_prev_q <= out_q;
    end
  end

  // Trigger qualification
  assign counter_rise = out_q && !out_prev_q && (cnt_state_q == AAC_CNT_RUN);
  assign ext_rise = ext_s2_q && !ext_prev_q && out_q;
  assign trigger = (counter_rise || ext_rise) && !acquisition_disable;
  assign convert_start = trigger && !busy_q;

  // Conversion in flight
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      busy_q <= 1'b0;
    end else if (convert_start) begin
      busy_q <= 1'b1;
    end else if (convert_done) begin
      busy_q <= 1'b0;
    end
  end

  // Result word: sign bit copied into the upper four bits
  assign result_word = {{(16-`AAC_ADC_W){convert_data[`AAC_ADC_W-1]}}, convert_data};
  assign fifo_full = (fill_q == (`AAC_PTR_W+1)'(`AAC_FIFO_DEPTH));
  assign push = convert_done && busy_q && !fifo_full;
  assign rd_fire = s_axi_arvalid && s_axi_arready;
  assign rd_addr = {s_axi_araddr[7:2], 2'b00};
  assign pop = rd_fire && (rd_addr == `AAC_ADDR_FIFO) && (fill_q != '0);

  // Result storage
  always_ff @(posedge aclk) begin
    if (push) begin
      fifo_mem[wr_ptr_q] <= result_word;
    end
  end

  // Pointers and fill level
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      fill_q <= '0;
    end else begin
      if (push) begin
        wr_ptr_q <= wr_ptr_q + `AAC_PTR_W'(1);
      end
      if (pop) begin
        rd_ptr_q <= rd_ptr_q + `AAC_PTR_W'(1);
      end
      if (push && !pop) begin
        fill_q <= fill_q + (`AAC_PTR_W+1)'(1);
      end else if (pop && !push) begin
        fill_q <= fill_q - (`AAC_PTR_W+1)'(1);
      end
    end
  end

  // Error flags: a new event wins over a clear in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      overflow_flag_q <= 1'b0;
      overrun_flag_q <= 1'b0;
    end else begin
      if (convert_done && busy_q && fifo_full) begin
        overflow_flag_q <= 1'b1;
      end else if (wr_fire && wr_addr == `AAC_ADDR_CLEAR) begin
        overflow_flag_q <= 1'b0;
      end
      if (trigger && busy_q) begin
        overrun_flag_q <= 1'b1;
      end else if (wr_fire && wr_addr == `AAC_ADDR_CLEAR) begin
        overrun_flag_q <= 1'b0;
      end
    end
  end

  assign result_available_flag = (fill_q != '0);
  assign acquisition_error_flag = overflow_flag_q || overrun_flag_q;

  // Read channel: one read at a time, data registered
  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `AAC_RESP_OKAY;
    end else if (rd_fire) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= `AAC_RESP_OKAY;
      case (rd_addr)
        `AAC_ADDR_STATUS1: begin
          s_axi_rdata <= {30'h0, acquisition_error_flag, result_available_flag};
        end
        `AAC_ADDR_STATUS2: begin
          s_axi_rdata <= {30'h0, overrun_flag_q, overflow_flag_q};
        end
        `AAC_ADDR_CMD1: begin
          s_axi_rdata <= {27'h0, cmd1_q};
        end
        `AAC_ADDR_CMD2: begin
          s_axi_rdata <= {30'h0, acquisition_disable, 1'b0};
        end
        `AAC_ADDR_CNT_DATA: begin
          s_axi_rdata <= {16'h0, count_q};
        end
        `AAC_ADDR_FIFO: begin
          s_axi_rdata <= pop ? {16'h0, fifo_mem[rd_ptr_q]} : 32'h0000_0000;
        end
        `AAC_ADDR_CNT_MODE, `AAC_ADDR_CLEAR: begin
          s_axi_rdata <= 32'h0000_0000;
        end
        default: begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= `AAC_RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule // aac_acquisition

// ===== testbench/aac_acquisition_checker.sv
module aac_acquisition_checker (
  input wire logic aclk, // Clock
  input wire logic aresetn, // Reset, low
  input wire logic s_axi_awready, // Write address ready
  input wire logic s_axi_bvalid, // Write response valid
  input wire logic s_axi_bready, // Response accept
  input wire logic s_axi_arready, // Read address ready
  input wire logic s_axi_rvalid, // Read data valid
  input wire logic s_axi_rready, // Read accept
  input wire logic [31:0] s_axi_rdata, // Read data
  input wire logic convert_start, // Start pulse
  input wire logic convert_done, // Converter done
  input wire logic sample_counter_output, // Interval output
  input wire aac_pkg::aac_cnt_state_t counter_state // Counter state
);
  timeunit 1ns;
  timeprecision 1ps;
  import aac_pkg::*;
  logic busy_q;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Tracks a conversion in flight
  always_ff @(posedge aclk) begin
    if (!aresetn) busy_q <= 1'b0;
    else if (convert_start) busy_q <= 1'b1;
    else if (convert_done) busy_q <= 1'b0;
  end
  start_one_cycle_a: assert property (convert_start |=> !convert_start)
    else $error("start pulse longer than one cycle");
  start_not_busy_a: assert property (convert_start |-> !busy_q)
    else $error("start while converter busy");
  lsb_out_high_a: assert property (counter_state == AAC_CNT_WAIT_LSB |-> sample_counter_output)
    else $error("output low after rate mode");
  msb_out_high_a: assert property (counter_state == AAC_CNT_WAIT_MSB |-> sample_counter_output)
    else $error("output moved before high byte");
  idle_out_low_a: assert property (counter_state == AAC_CNT_IDLE |-> !sample_counter_output)
    else $error("output high while stopped");
  low_tick_a: assert property ($fell(sample_counter_output) && counter_state == AAC_CNT_RUN
    |=> !sample_counter_output [*8])
    else $error("output low phase too short");
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data not held");
  aw_block_a: assert property (s_axi_bvalid |-> !s_axi_awready)
    else $error("write address taken during response");
endmodule // aac_acquisition_checker

bind aac_acquisition aac_acquisition_checker chk_u (.aclk(aclk), .aresetn(aresetn),
  .s_axi_awready(s_axi_awready), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .s_axi_rdata(s_axi_rdata), .convert_start(convert_start), .convert_done(convert_done),
  .sample_counter_output(sample_counter_output), .counter_state(counter_state));

// ===== testbench/aac_conv_model.sv
module aac_conv_model (
  input wire logic aclk, // Clock
  input wire logic aresetn, // Reset, low
  input wire logic convert_start, // Start pulse
  input wire logic [7:0] lat, // Conversion time in cycles
  input wire logic [11:0] val, // Value to return
  output logic convert_done, // Done pulse
  output logic [11:0] convert_data // Result
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] cnt_q;
  logic busy_q;
  logic [11:0] last_q;
  // Converter ignores starts while busy, answers lat+1 cycles after a start
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      busy_q <= 1'b0;
      convert_done <= 1'b0;
      cnt_q <= 8'h00;
      last_q <= 12'h000;
    end else begin
      convert_done <= 1'b0;
      if (convert_start && !busy_q) begin
        busy_q <= 1'b1;
        cnt_q <= lat;
      end else if (busy_q && cnt_q == 8'h00) begin
        busy_q <= 1'b0;
        convert_done <= 1'b1;
        last_q <= val;
      end else if (busy_q) cnt_q <= cnt_q - 8'h01;
    end
  end
  // Data invalid outside the done cycle
  assign convert_data = convert_done ? last_q : ~last_q;
endmodule // aac_conv_model

// ===== testbench/tb.sv
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import aac_pkg::*;
  logic aclk, aresetn, awv, awr, wv, wr_r, bv, br, arv, arr, rv, rr, ext_n, cs, cd, sco, sen;
  logic [31:0] awa, wd, ara, rdat, rd_q;
  logic [1:0] bresp, rresp, rs_q, bs_q;
  logic [11:0] cdat, val;
  logic [7:0] lat;
  logic [3:0] chan;
  aac_cnt_state_t cst;
  int fails, n_tests, i, k;
  aac_acquisition dut_u (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa), .s_axi_awprot(3'h0),
    .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(wv), .s_axi_wready(wr_r), .s_axi_bresp(bresp), .s_axi_bvalid(bv),
    .s_axi_bready(br), .s_axi_araddr(ara), .s_axi_arprot(3'h0), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_rdata(rdat), .s_axi_rresp(rresp), .s_axi_rvalid(rv),
    .s_axi_rready(rr), .external_convert_n(ext_n), .convert_start(cs), .convert_done(cd),
    .convert_data(cdat), .sample_counter_output(sco), .channel_select(chan),
    .scan_enable_n(sen), .counter_state(cst));
  aac_conv_model conv_u (.aclk(aclk), .aresetn(aresetn), .convert_start(cs), .lat(lat),
    .val(val), .convert_done(cd), .convert_data(cdat));
  // Clock
  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end
  task report_and_stop;
    $display("comparisons=%0d mismatches=%0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task tmo(input int n);
    if (n >= 200) begin
      fails++;
      report_and_stop();
    end
  endtask
  // Bus write: sample handshakes before the edge, release after it
  task wr(input logic [7:0] a, input logic [31:0] d);
    logic ta, tw, fin;
    int n;
    fin = 1'b0;
    @(posedge aclk);
    awa <= {24'h0, a}; wd <= d; awv <= 1'b1; wv <= 1'b1; br <= 1'b1;
    // Runs until the response has been seen; the request flags are not yet updated here
    for (n = 0; n < 200 && !fin; n++) begin
      @(negedge aclk);
      ta = awv & awr;
      tw = wv & wr_r;
      fin = bv;
      if (fin) bs_q = bresp;
      @(posedge aclk);
      if (ta) awv <= 1'b0;
      if (tw) wv <= 1'b0;
      if (fin) br <= 1'b0;
    end
    if (!fin) tmo(200);
  endtask
  // Bus read: result in rd_q and rs_q
  task rd(input logic [7:0] a);
    logic ta, fin;
    int n;
    fin = 1'b0;
    @(posedge aclk);
    ara <= {24'h0, a}; arv <= 1'b1; rr <= 1'b1;
    for (n = 0; n < 200 && !fin; n++) begin
      @(negedge aclk);
      ta = arv & arr;
      fin = rv;
      if (fin) begin
        rd_q = rdat;
        rs_q = rresp;
      end
      @(posedge aclk);
      if (ta) arv <= 1'b0;
      if (fin) rr <= 1'b0;
    end
    if (!fin) tmo(200);
  endtask
  task pulse;
    @(posedge aclk) ext_n <= 1'b0;
    repeat (4) @(posedge aclk);
    ext_n <= 1'b1;
    repeat (6) @(posedge aclk);
  endtask
  // Waits for the next rise of the interval output, counting cycles
  task rise(inout int c);
    for (; sco !== 1'b0 && c < 2000; c++) @(negedge aclk);
    for (; sco !== 1'b1 && c < 2000; c++) @(negedge aclk);
    if (c >= 2000) tmo(200);
  endtask
  initial begin
    fails = 0; n_tests = 0; aresetn = 1'b0; awv = 0; wv = 0; br = 0; arv = 0; rr = 0;
    awa = 0; wd = 0; ara = 0; ext_n = 1'b1; lat = 8'h04; val = 12'h000;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    wr(8'h08, 32'h1a); chk(bs_q, 2'b00); rd(8'h08); chk(rd_q, 32'h1a);
    chk({chan, sen}, 5'h15);
    rd(8'h40); chk(rs_q, 2'b10);
    wr(8'h40, 32'h0); chk(bs_q, 2'b10);
    $display("test done: registers");
    pulse(); rd(8'h00); chk(rd_q, 0);
    rd(8'h1c); chk(rd_q[15:0], 0); rd(8'h04); chk(rd_q, 0);
    $display("test done: gating");
    wr(8'h10, 32'h34); chk(sco, 1);
    val <= 12'h800; pulse(); repeat (20) @(posedge aclk);
    rd(8'h00); chk(rd_q, 1);
    rd(8'h1c); chk(rd_q[15:0], 16'hf800);
    wr(8'h0c, 32'h2); pulse(); rd(8'h00); chk(rd_q, 0);
    wr(8'h0c, 32'h0);
    $display("test done: external trigger");
    lat <= 8'd100; pulse(); pulse(); repeat (120) @(posedge aclk);
    rd(8'h04); chk(rd_q, 2);
    rd(8'h00); chk(rd_q, 3);
    wr(8'h18, 32'h0); rd(8'h04); chk(rd_q, 0);
    rd(8'h1c); lat <= 8'h02;
    $display("test done: overrun");
    val <= 12'h3ff;
    for (i = 0; i < 520; i++) pulse();
    rd(8'h04); chk(rd_q, 1);
    for (i = 0; i < 512; i++) rd(8'h1c);
    chk(rd_q[15:0], 16'h03ff); rd(8'h00); chk(rd_q, 2);
    $display("test done: overflow");
    wr(8'h10, 32'h34); wr(8'h14, 32'd10); chk(cst, AAC_CNT_WAIT_MSB);
    wr(8'h18, 32'h0); rd(8'h1c);
    wr(8'h14, 32'h0); chk(cst, AAC_CNT_RUN);
    k = 0; rise(k); k = 0; rise(k); chk(k, 400);
    rd(8'h00); chk(rd_q[0], 1);
    // Rate mode rewrite must park the output high: no dip over more than one period
    wr(8'h10, 32'h34); chk(cst, AAC_CNT_WAIT_LSB);
    k = 0;
    for (i = 0; i < 450; i++) begin
      @(negedge aclk);
      if (sco !== 1'b1) k++;
    end
    chk(k, 0);
    wr(8'h10, 32'h30); chk(sco, 0);
    $display("test done: interval counter");
    report_and_stop();
  end
endmodule // tb
